// ==== shared/i2c_regs_pkg.sv ====
// Operation
// - seven-bit addressing, standard and fast speeds
// - answer slave address 0x18 and the general call address
// - slave only, never drives clock
// - data sampled on clock high, eight bits
// - detect start and stop conditions
// - acknowledge each received byte on ninth clock
// - released data during acknowledge means not-acknowledge
// - start while active is repeated start; with detector on, only in a byte's first bit or a read byte
// - acknowledge general call address zero
// - auto-increment register pointer on writes
// - auto-increment register pointer on acked reads
// - error detector on by default, status readable
// - abandon corrupted transaction on bus error
// - two pages of 128 byte registers
// - address zero controls page everywhere
// - reset selects page zero
// - write one or zero selects page
// - page bit only in bit zero
package i2c_regs_pkg;
	localparam logic [6:0] SLAVE_ADDR = 7'h18;
	localparam logic [6:0] GENERAL_CALL = 7'h00;
	localparam logic [6:0] PAGE_CTRL_OFS = 7'h00;
	localparam logic [6:0] DEBUG_OFS = 7'h6B;
	localparam int PAGE_BIT = 0;
	localparam int ERR_STATUS_BIT = 0;
	localparam int ERR_DISABLE_BIT = 2;
	localparam int ROUTE_BIT = 3;
	localparam logic [7:0] DEBUG_RESET = 8'h00;
	localparam int REGS_PER_PAGE = 128;
	localparam logic [3:0] BITS_PER_BYTE = 4'h8;
endpackage

// ==== rtl/paged_i2c_control_slave.sv ====
`timescale 1ns/1ns
module paged_i2c_control_slave (
	input wire logic clock_in,
	input wire logic rst_in,
	input wire logic scl_in,
	input wire logic sda_in,
	output logic sda_out,
	output logic sda_oe_n_out,
	output logic record_route_out,
	output logic active_page_out
);
	typedef enum logic [2:0] {
		ST_IDLE, ST_ADDR, ST_ADDR_ACK, ST_WRITE, ST_WRITE_ACK, ST_READ, ST_READ_ACK
	} phase_e;

	typedef struct packed {
		phase_e phase;
		logic scl_prev;
		logic sda_prev;
		logic [3:0] bit_cnt;
		logic [7:0] shift;
		logic is_read;
		logic ptr_loaded;
		logic [6:0] ptr;
		logic page;
		logic [7:0] debug;
		logic err_flag;
		logic drive_low;
		logic acking;
	} state_s;

	state_s q;
	state_s d;
	logic [7:0] mem_q [0:2*i2c_regs_pkg::REGS_PER_PAGE-1];
	logic mem_we;
	logic [7:0] mem_wdata;
	logic [7:0] mem_waddr;

	// pointer step; seven bits so 127 wraps to 0
	function automatic logic [6:0] ptr_next(input logic [6:0] p);
		return p + 7'h01;
	endfunction

	// debug register lives on page 0 only, page 1 keeps ordinary storage there
	function automatic logic debug_hit(input logic [6:0] a, input logic pg);
		return a == i2c_regs_pkg::DEBUG_OFS && !pg;
	endfunction

	// register readback: page control is shared, debug is on page 0 only, others are paged
	function automatic logic [7:0] read_reg(input logic [6:0] a, input logic pg,
			input logic [7:0] dbg, input logic err);
		logic [7:0] r;
		r = 8'h00;
		if (a == i2c_regs_pkg::PAGE_CTRL_OFS) begin
			r = {7'h00, pg};
		end else if (debug_hit(a, pg)) begin
			r = dbg;
			r[i2c_regs_pkg::ERR_STATUS_BIT] = err;
		end else begin
			r = mem_q[{pg, a}];
		end
		return r;
	endfunction

	logic scl_rise;
	logic scl_fall;
	logic start_cond;
	logic stop_cond;
	logic glitch;

	// edge and condition decode on synchronous bus inputs
	always_comb begin
		scl_rise = scl_in && !q.scl_prev;
		scl_fall = !scl_in && q.scl_prev;
		start_cond = scl_in && q.scl_prev && q.sda_prev && !sda_in;
		stop_cond = scl_in && q.scl_prev && !q.sda_prev && sda_in;
		// data moving while clock high in any phase but idle or a read byte we send is a corrupt frame;
		// the first bit's high time is where a legal stop or repeated start lands
		glitch = (start_cond || stop_cond) && q.phase != ST_IDLE && q.bit_cnt > 4'h1
			&& q.phase != ST_READ;
	end

	// next-state logic for the whole slave
	always_comb begin
		d = q;
		mem_we = 1'b0;
		mem_wdata = q.shift;
		mem_waddr = {q.page, q.ptr};
		d.scl_prev = scl_in;
		d.sda_prev = sda_in;
		if (glitch && !q.debug[i2c_regs_pkg::ERR_DISABLE_BIT]) begin
			d.err_flag = 1'b1;
			d.phase = ST_IDLE;
			d.drive_low = 1'b0;
		end else if (start_cond) begin
			d.phase = ST_ADDR;
			d.bit_cnt = 4'h0;
			d.drive_low = 1'b0;
		end else if (stop_cond) begin
			d.phase = ST_IDLE;
			d.drive_low = 1'b0;
		end else if (scl_rise) begin
			// sample on the clock high edge
			if (q.phase == ST_ADDR || q.phase == ST_WRITE) begin
				d.shift = {q.shift[6:0], sda_in};
				d.bit_cnt = q.bit_cnt + 4'h1;
			end else if (q.phase == ST_READ_ACK) begin
				d.acking = !sda_in;
			end
		end else if (scl_fall) begin
			case (q.phase)
				ST_ADDR: begin
					if (q.bit_cnt == i2c_regs_pkg::BITS_PER_BYTE) begin
						if (q.shift[7:1] == i2c_regs_pkg::SLAVE_ADDR ||
								q.shift[7:1] == i2c_regs_pkg::GENERAL_CALL) begin
							d.phase = ST_ADDR_ACK;
							d.is_read = q.shift[0] && q.shift[7:1] != i2c_regs_pkg::GENERAL_CALL;
							d.ptr_loaded = 1'b0;
							d.drive_low = 1'b1;
						end else begin
							d.phase = ST_IDLE;
						end
					end
				end
				ST_ADDR_ACK: begin
					d.bit_cnt = 4'h0;
					if (q.is_read) begin
						d.phase = ST_READ;
						d.shift = read_reg(q.ptr, q.page, q.debug, q.err_flag);
						d.drive_low = !d.shift[7];
					end else begin
						d.phase = ST_WRITE;
						d.drive_low = 1'b0;
					end
				end
				ST_WRITE: begin
					if (q.bit_cnt == i2c_regs_pkg::BITS_PER_BYTE) begin
						d.phase = ST_WRITE_ACK;
						d.drive_low = 1'b1;
						if (!q.ptr_loaded) begin
							d.ptr = q.shift[6:0];
							d.ptr_loaded = 1'b1;
						end else begin
							if (q.ptr == i2c_regs_pkg::PAGE_CTRL_OFS) begin
								d.page = q.shift[i2c_regs_pkg::PAGE_BIT];
							end else if (debug_hit(q.ptr, q.page)) begin
								d.debug = q.shift;
							end else begin
								mem_we = 1'b1;
							end
							d.ptr = ptr_next(q.ptr);
						end
					end
				end
				ST_WRITE_ACK: begin
					d.phase = ST_WRITE;
					d.bit_cnt = 4'h0;
					d.drive_low = 1'b0;
				end
				ST_READ: begin
					d.bit_cnt = q.bit_cnt + 4'h1;
					if (q.bit_cnt == 4'h7) begin
						d.phase = ST_READ_ACK;
						d.drive_low = 1'b0;
					end else begin
						d.shift = {q.shift[6:0], 1'b0};
						d.drive_low = !q.shift[6];
					end
				end
				ST_READ_ACK: begin
					if (q.acking) begin
						d.ptr = ptr_next(q.ptr);
						d.phase = ST_READ;
						d.bit_cnt = 4'h0;
						d.shift = read_reg(d.ptr, q.page, q.debug, q.err_flag);
						d.drive_low = !d.shift[7];
					end else begin
						d.phase = ST_IDLE;
					end
				end
				default: begin
					d.drive_low = 1'b0;
				end
			endcase
		end
	end

	// state register; page and detector enable return to defaults on reset
	always_ff @(posedge clock_in) begin
		if (rst_in) begin
			q <= '0;
			q.phase <= ST_IDLE;
			q.scl_prev <= 1'b1;
			q.sda_prev <= 1'b1;
			q.page <= 1'b0;
			q.debug <= i2c_regs_pkg::DEBUG_RESET;
		end else begin
			q <= d;
		end
	end

	// paged storage, not reset like real control latches
	always_ff @(posedge clock_in) begin
		if (mem_we) begin
			mem_q[mem_waddr] <= mem_wdata;
		end
	end

	// open drain: only pull low, never drive the clock line
	assign sda_out = 1'b0;
	assign sda_oe_n_out = !q.drive_low;
	assign record_route_out = q.debug[i2c_regs_pkg::ROUTE_BIT];
	assign active_page_out = q.page;


	// line ownership checks: pull low only while acking or sending a zero
	ack_low_a: assert property (@(posedge clock_in) disable iff (rst_in)
		(q.phase == ST_ADDR_ACK || q.phase == ST_WRITE_ACK) |-> !sda_oe_n_out)
		else $error("ack not driven low");
	release_a: assert property (@(posedge clock_in) disable iff (rst_in)
		(q.phase == ST_IDLE || q.phase == ST_READ_ACK) |-> sda_oe_n_out)
		else $error("data line not released");
	never_high_a: assert property (@(posedge clock_in) disable iff (rst_in)
		!sda_oe_n_out |-> !sda_out)
		else $error("line driven high");

	// bus condition handling
	stop_idle_a: assert property (@(posedge clock_in) disable iff (rst_in)
		stop_cond && !glitch |=> q.phase == ST_IDLE)
		else $error("stop did not idle");
	start_addr_a: assert property (@(posedge clock_in) disable iff (rst_in)
		start_cond && !glitch |=> q.phase == ST_ADDR && q.bit_cnt == 4'h0)
		else $error("start not seen");

	// page select and pointer stepping on writes
	page_write_a: assert property (@(posedge clock_in) disable iff (rst_in)
		scl_fall && !start_cond && !stop_cond && q.phase == ST_WRITE && q.bit_cnt == 4'h8
		&& q.ptr_loaded && q.ptr == 7'h00 |=> q.page == $past(q.shift[0]))
		else $error("page not updated");
	incr_a: assert property (@(posedge clock_in) disable iff (rst_in)
		scl_fall && !start_cond && !stop_cond && q.phase == ST_WRITE && q.bit_cnt == 4'h8
		&& q.ptr_loaded |=> q.ptr == $past(q.ptr) + 7'h01)
		else $error("pointer not advanced");

	// error detector abandons the frame and latches its status
	err_abort_a: assert property (@(posedge clock_in) disable iff (rst_in)
		glitch && !q.debug[2] |=> q.err_flag && q.phase == ST_IDLE)
		else $error("error not handled");

	// addresses that are not ours go quiet until the next start
	foreign_a: assert property (@(posedge clock_in) disable iff (rst_in)
		scl_fall && !start_cond && !stop_cond && q.phase == ST_ADDR && q.bit_cnt == 4'h8
		&& q.shift[7:1] != 7'h18 && q.shift[7:1] != 7'h00 |=> q.phase == ST_IDLE)
		else $error("foreign address answered");

	// own address moves on to the acknowledge bit
	own_addr_a: assert property (@(posedge clock_in) disable iff (rst_in)
		scl_fall && q.phase == ST_ADDR && q.bit_cnt == i2c_regs_pkg::BITS_PER_BYTE
		&& q.shift[7:1] == i2c_regs_pkg::SLAVE_ADDR
		|=> q.phase == ST_ADDR_ACK && q.drive_low)
		else $error("own address not acknowledged");

	// direction bit latched from the address byte
	dir_latch_a: assert property (@(posedge clock_in) disable iff (rst_in)
		scl_fall && q.phase == ST_ADDR && q.bit_cnt == i2c_regs_pkg::BITS_PER_BYTE
		&& q.shift[7:1] == i2c_regs_pkg::SLAVE_ADDR
		|=> q.is_read == $past(q.shift[0]))
		else $error("direction bit lost");

	// general call is acknowledged and always taken as a write
	gen_call_a: assert property (@(posedge clock_in) disable iff (rst_in)
		scl_fall && q.phase == ST_ADDR && q.bit_cnt == i2c_regs_pkg::BITS_PER_BYTE
		&& q.shift[7:1] == i2c_regs_pkg::GENERAL_CALL
		|=> q.phase == ST_ADDR_ACK && !q.is_read)
		else $error("general call ignored");

	// a foreign address never pulls the line
	foreign_quiet_a: assert property (@(posedge clock_in) disable iff (rst_in)
		scl_fall && q.phase == ST_ADDR && q.bit_cnt == i2c_regs_pkg::BITS_PER_BYTE
		&& q.shift[7:1] != i2c_regs_pkg::SLAVE_ADDR
		&& q.shift[7:1] != i2c_regs_pkg::GENERAL_CALL |=> sda_oe_n_out)
		else $error("foreign address pulled line");

	// first write byte after the address is the pointer
	ptr_load_a: assert property (@(posedge clock_in) disable iff (rst_in)
		scl_fall && q.phase == ST_WRITE && q.bit_cnt == i2c_regs_pkg::BITS_PER_BYTE
		&& !q.ptr_loaded
		|=> q.ptr_loaded && q.ptr == $past(q.shift[6:0]))
		else $error("pointer not loaded");

	// after a write ack the line is let go for the master's next byte
	wr_ack_rel_a: assert property (@(posedge clock_in) disable iff (rst_in)
		scl_fall && q.phase == ST_WRITE_ACK
		|=> sda_oe_n_out && q.phase == ST_WRITE && q.bit_cnt == 4'h0)
		else $error("write ack held too long");

	// read entry starts a fresh byte from the pointed register
	read_enter_a: assert property (@(posedge clock_in) disable iff (rst_in)
		scl_fall && q.phase == ST_ADDR_ACK && q.is_read
		|=> q.phase == ST_READ && q.bit_cnt == 4'h0)
		else $error("read not entered");

	// the line always shows the shift register's top bit while sending
	read_bit_a: assert property (@(posedge clock_in) disable iff (rst_in)
		q.phase == ST_READ |-> sda_oe_n_out == q.shift[7])
		else $error("read bit not on line");

	// master ack moves on to the next register
	read_incr_a: assert property (@(posedge clock_in) disable iff (rst_in)
		scl_fall && q.phase == ST_READ_ACK && q.acking
		|=> q.phase == ST_READ && q.ptr == $past(q.ptr) + 7'h01)
		else $error("read pointer not advanced");

	// master not-ack ends the read
	nack_idle_a: assert property (@(posedge clock_in) disable iff (rst_in)
		scl_fall && q.phase == ST_READ_ACK && !q.acking |=> q.phase == ST_IDLE)
		else $error("read not ended on nack");

	// the bit counter never runs past one byte
	bit_range_a: assert property (@(posedge clock_in) disable iff (rst_in)
		q.bit_cnt <= i2c_regs_pkg::BITS_PER_BYTE)
		else $error("bit counter overrun");

	// error status is sticky until reset
	err_sticky_a: assert property (@(posedge clock_in) disable iff (rst_in)
		q.err_flag |=> q.err_flag)
		else $error("error status lost");

	// a disabled detector leaves the status alone
	detect_off_a: assert property (@(posedge clock_in) disable iff (rst_in)
		glitch && q.debug[i2c_regs_pkg::ERR_DISABLE_BIT]
		|=> q.err_flag == $past(q.err_flag))
		else $error("disabled detector fired");

	// page only moves on a write to the page control register
	page_hold_a: assert property (@(posedge clock_in) disable iff (rst_in)
		!(scl_fall && q.phase == ST_WRITE && q.bit_cnt == i2c_regs_pkg::BITS_PER_BYTE
		&& q.ptr_loaded && q.ptr == i2c_regs_pkg::PAGE_CTRL_OFS)
		|=> q.page == $past(q.page))
		else $error("page changed unasked");

	// shared registers never land in paged storage
	store_page_a: assert property (@(posedge clock_in) disable iff (rst_in)
		mem_we |-> q.ptr != i2c_regs_pkg::PAGE_CTRL_OFS && !debug_hit(q.ptr, q.page))
		else $error("shared register stored");

	// reset returns page 0, clears the status and releases the line
	reset_page_a: assert property (@(posedge clock_in)
		rst_in |=> !q.page && !q.err_flag && sda_oe_n_out)
		else $error("reset state wrong");
endmodule // paged_i2c_control_slave

// ==== sim/i2c_master_model.sv ====
`timescale 1ns/1ns
module i2c_master_model (
	input wire logic clock_in,
	input wire logic dev_oe_n_in,
	input wire logic dev_sda_in,
	output logic scl_out,
	output logic sda_out
);
	logic scl_q = 1'b1;
	logic sda_q = 1'b1;
	// open-drain data with pull-up; only the master owns the clock
	assign scl_out = scl_q;
	assign sda_out = sda_q & (dev_oe_n_in | dev_sda_in);
	// four cycles per level, double what the slave needs
	task automatic phase(input logic c, input logic d);
		@(negedge clock_in);
		scl_q = c;
		sda_q = d;
		repeat (3) @(negedge clock_in);
	endtask
	task automatic bit_io(input logic d, output logic q);
		phase(1'b0, sda_q);
		phase(1'b0, d);
		phase(1'b1, d);
		q = sda_out;
	endtask
	// clock drops first so a repeated start never looks like a stop
	task automatic start();
		phase(1'b0, sda_q);
		phase(1'b0, 1'b1);
		phase(1'b1, 1'b1);
		phase(1'b1, 1'b0);
	endtask
	task automatic stop();
		phase(1'b0, sda_q);
		phase(1'b0, 1'b0);
		phase(1'b1, 1'b0);
		phase(1'b1, 1'b1);
	endtask
	task automatic xfer(input logic [7:0] tx, input logic ack_in,
		output logic [7:0] rx, output logic ack_out);
		for (int i = 7; i >= 0; i--) begin
			bit_io(tx[i], rx[i]);
		end
		bit_io(ack_in, ack_out);
	endtask
endmodule // i2c_master_model

// ==== sim/testbench.sv ====
`timescale 1ns/1ns
module testbench;
	logic clock_in = 1'b0;
	logic rst_in = 1'b1;
	logic scl, sda, sda_drv, sda_oe_n, route, page, ack;
	logic [7:0] rx;
	int n_errors = 0;
	int check_count = 0;
	initial begin
		forever #5 clock_in = ~clock_in;
	end
	paged_i2c_control_slave i_dut (.clock_in(clock_in), .rst_in(rst_in), .scl_in(scl),
		.sda_in(sda), .sda_out(sda_drv), .sda_oe_n_out(sda_oe_n),
		.record_route_out(route), .active_page_out(page));
	i2c_master_model i_master (.clock_in(clock_in), .dev_oe_n_in(sda_oe_n),
		.dev_sda_in(sda_drv), .scl_out(scl), .sda_out(sda));
	task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
		check_count++;
		if (seen !== exp) begin
			n_errors++;
			$display("mismatch %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic close_out();
		if (n_errors == 0 && check_count > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask
	task automatic put(input logic [7:0] b);
		i_master.xfer(b, 1'b1, rx, ack);
		check("ack", {7'h00, ack}, 8'h00);
	endtask
	// pointer byte first, then data bytes in order
	task automatic wr(input logic [6:0] ptr, input logic [7:0] d[$]);
		i_master.start();
		put({i2c_regs_pkg::SLAVE_ADDR, 1'b0});
		put({1'b0, ptr});
		foreach (d[i]) put(d[i]);
		i_master.stop();
	endtask
	// last byte is not acknowledged so the slave lets go
	task automatic rd(input logic [6:0] ptr, input logic [7:0] e[$]);
		i_master.start();
		put({i2c_regs_pkg::SLAVE_ADDR, 1'b0});
		put({1'b0, ptr});
		i_master.start();
		put({i2c_regs_pkg::SLAVE_ADDR, 1'b1});
		foreach (e[i]) begin
			i_master.xfer(8'hFF, (i == e.size() - 1), rx, ack);
			check("read data", rx, e[i]);
		end
		i_master.stop();
	endtask
	// stop three bits into a byte: a glitch to the error detector
	task automatic abort_frame();
		i_master.start();
		put({i2c_regs_pkg::SLAVE_ADDR, 1'b0});
		repeat (3) i_master.bit_io(1'b0, ack);
		i_master.stop();
	endtask
	// tests
	initial begin
		repeat (8) @(negedge clock_in);
		rst_in = 1'b0;
		check("page", {7'h00, page}, 8'h00);
		check("release", {7'h00, sda_oe_n}, 8'h01);
		rd(i2c_regs_pkg::DEBUG_OFS, {i2c_regs_pkg::DEBUG_RESET});
		wr(7'h05, {8'hA5, 8'h3C, 8'h81});
		rd(7'h05, {8'hA5, 8'h3C, 8'h81});
		wr(7'h00, {8'h01});
		check("page", {7'h00, page}, 8'h01);
		rd(7'h00, {8'h01});
		wr(7'h05, {8'h5A});
		rd(7'h05, {8'h5A});
		wr(7'h00, {8'h00});
		rd(7'h05, {8'hA5});
		// foreign address gets no answer, general call does
		i_master.start();
		i_master.xfer({7'h19, 1'b0}, 1'b1, rx, ack);
		check("foreign ack", {7'h00, ack}, 8'h01);
		i_master.start();
		put({i2c_regs_pkg::GENERAL_CALL, 1'b0});
		i_master.stop();
		abort_frame();
		rd(i2c_regs_pkg::DEBUG_OFS, {8'h01});
		wr(i2c_regs_pkg::DEBUG_OFS, {8'h08});
		check("route", {7'h00, route}, 8'h01);
		// second reset in mid-run from page 1, then a disabled detector
		wr(7'h00, {8'h01});
		rst_in = 1'b1;
		repeat (8) @(negedge clock_in);
		rst_in = 1'b0;
		check("page", {7'h00, page}, 8'h00);
		check("route", {7'h00, route}, 8'h00);
		rd(i2c_regs_pkg::DEBUG_OFS, {8'h00});
		wr(i2c_regs_pkg::DEBUG_OFS, {8'h04});
		abort_frame();
		rd(i2c_regs_pkg::DEBUG_OFS, {8'h04});
		close_out();
	end
	// a full run needs under ten thousand cycles
	initial begin
		repeat (50000) @(posedge clock_in);
		n_errors++;
		close_out();
	end
endmodule // testbench
